// File: amdc_pkg.sv
// amdc_pkg: register map, field positions, commands, protocol codes, timing and states
// for the transmitter modulation depth control block.
// assumes a host that writes registers and issues direct commands on sys_clk.

package amdc_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0] REG_AUX_DEF    = 6'h01;
  localparam logic [5:0] REG_PROTOCOL   = 6'h02;
  localparam logic [5:0] REG_DEPTH_CTRL = 6'h03;
  localparam logic [5:0] REG_DEPTH_DISP = 6'h04;
  localparam logic [5:0] REG_NORMAL_LVL = 6'h05;
  localparam logic [5:0] REG_MOD_LVL    = 6'h06;
  localparam logic [5:0] REG_ADC_OUT    = 6'h07;
  localparam logic [5:0] REG_STATUS     = 6'h08;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int AUX_TX_EN_BIT   = 3;
  localparam int AUX_AM_BIT      = 5;
  localparam int DEPTH_SRC_BIT   = 7;
  localparam int DEPTH_FRAC_MSB  = 6;
  localparam int DEPTH_FRAC_LSB  = 1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam logic [7:0] RST_AUX_DEF    = 8'h00;
  localparam logic [7:0] RST_PROTOCOL   = 8'h00;
  localparam logic [7:0] RST_DEPTH_CTRL = 8'h00;
  localparam logic [7:0] RST_NORMAL_LVL = 8'h00;
  localparam logic [7:0] RST_MOD_LVL    = 8'h00;
  localparam logic [7:0] FRAC_ONE       = 8'h40;   // 1.0 in six fraction bits

  // ----------------------------------------------------------------------
  // direct commands and protocol codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_ANALOG_PRESET = 8'hC0;
  localparam logic [7:0] CMD_CAL_DEPTH     = 8'hC1;
  localparam logic [2:0] PROTO_ISO_A       = 3'h0;
  localparam logic [2:0] PROTO_ISO_B       = 3'h1;
  localparam logic [2:0] PROTO_PROP_212    = 3'h2;
  localparam logic [2:0] PROTO_NFC_106     = 3'h3;
  localparam logic [2:0] PROTO_NFC_212     = 3'h4;
  localparam logic [2:0] PROTO_NFC_424     = 3'h5;
  localparam logic [2:0] PROTO_VICINITY    = 3'h6;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TX_SETTLE_NS  = 10000;
  localparam int TX_SETTLE_CYC = (TX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_TX_ON      = 3'b001,
    ST_MEAS_REF   = 3'b010,
    ST_WAIT_REF   = 3'b011,
    ST_CALC       = 3'b100,
    ST_TRIAL      = 3'b101,
    ST_WAIT_TRIAL = 3'b110,
    ST_FINISH     = 3'b111
  } amdc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] data;
  } amdc_reg_req_t;

  typedef struct packed {
    logic [7:0] antenna_driver_out_a;
    logic [7:0] antenna_driver_out_b;
  } amdc_drive_t;

endpackage

// File: amdc_depth_cal.sv
// amdc_depth_cal: transmitter modulation control with automatic depth trim.
// assumes an a/d converter on sys_clk that answers adc_start with adc_done
// and adc_value, and a framing block that drives mod_active.

`timescale 1ns/100ps

module amdc_depth_cal
  import amdc_pkg::*;
#(
  parameter int SETTLE_CYC = TX_SETTLE_CYC
) (
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  input  wire amdc_reg_req_t reg_req,
  output logic [7:0]         reg_rdata,
  input  wire logic          cmd_valid,
  input  wire logic [7:0]    cmd_code,
  input  wire logic          mod_active,
  output logic               adc_start,
  input  wire logic          adc_done,
  input  wire logic [7:0]    adc_value,
  output logic               tx_on,
  output amdc_drive_t        drive,
  output logic               cal_busy,
  output logic               cal_done
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // target = ref * 64 / (64 + frac); larger code, deeper modulation
  function automatic logic [7:0] calc_target(input logic [7:0] ref_amp,
                                             input logic [5:0] frac);
    logic [13:0] num;
    logic [6:0]  den;
    logic [13:0] quo;
    num = {ref_amp, 6'h00};
    den = 7'(FRAC_ONE) + {1'b0, frac};
    quo = num / {7'h00, den};
    return quo[7:0];
  endfunction

  function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
    return (a >= b) ? (a - b) : (b - a);
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  amdc_state_t state, next_state;
  logic [7:0]  aux_def, next_aux_def;
  logic [7:0]  protocol, next_protocol;
  logic [7:0]  depth_ctrl, next_depth_ctrl;
  logic [7:0]  depth_disp, next_depth_disp;
  logic [7:0]  normal_lvl, next_normal_lvl;
  logic [7:0]  mod_lvl, next_mod_lvl;
  logic [7:0]  adc_out, next_adc_out;
  logic        done_flag, next_done_flag;
  logic [7:0]  next_reg_rdata;
  logic [8:0]  settle_cnt, next_settle_cnt;
  logic [7:0]  target, next_target;
  logic [7:0]  sar_code, next_sar_code;
  logic [7:0]  probe, next_probe;
  logic [2:0]  bit_idx, next_bit_idx;
  logic [7:0]  best_code, next_best_code;
  logic [7:0]  best_err, next_best_err;
  logic        next_cal_done;
  amdc_drive_t next_drive;
  logic [7:0]  seg_off;
  logic [7:0]  err;
  logic        cal_cmd, preset_cmd, calibrating, am_proto;

  assign cal_cmd     = cmd_valid && (cmd_code == CMD_CAL_DEPTH) && (state == ST_IDLE);
  assign preset_cmd  = cmd_valid && (cmd_code == CMD_ANALOG_PRESET) && (state == ST_IDLE);
  assign calibrating = (state != ST_IDLE);
  assign am_proto    = (protocol[2:0] == PROTO_ISO_B) || (protocol[2:0] == PROTO_PROP_212) ||
                       (protocol[2:0] == PROTO_NFC_212) || (protocol[2:0] == PROTO_NFC_424);
  assign err         = abs_diff(adc_value, target);
  assign adc_start   = (state == ST_MEAS_REF) || (state == ST_TRIAL);
  assign cal_busy    = calibrating;
  assign tx_on       = aux_def[AUX_TX_EN_BIT] || calibrating;

  // ----------------------------------------------------------------------
  // host register file and direct command side effects
  // ----------------------------------------------------------------------
  always_comb begin
    next_aux_def    = aux_def;
    next_protocol   = protocol;
    next_depth_ctrl = depth_ctrl;
    next_normal_lvl = normal_lvl;
    next_mod_lvl    = mod_lvl;
    next_reg_rdata  = reg_rdata;
    if (reg_req.wr) begin
      if (reg_req.addr == REG_AUX_DEF) begin
        next_aux_def = reg_req.data;
      end else if (reg_req.addr == REG_PROTOCOL) begin
        next_protocol = reg_req.data;
      end else if (reg_req.addr == REG_DEPTH_CTRL) begin
        next_depth_ctrl = reg_req.data;
      end else if (reg_req.addr == REG_NORMAL_LVL) begin
        next_normal_lvl = reg_req.data;
      end else if (reg_req.addr == REG_MOD_LVL) begin
        next_mod_lvl = reg_req.data;
      end
    end
    // preset forces the keying choice from the configured protocol
    if (preset_cmd) begin
      next_aux_def[AUX_AM_BIT] = am_proto;
    end
    if (reg_req.rd) begin
      if (reg_req.addr == REG_AUX_DEF) begin
        next_reg_rdata = aux_def;
      end else if (reg_req.addr == REG_PROTOCOL) begin
        next_reg_rdata = protocol;
      end else if (reg_req.addr == REG_DEPTH_CTRL) begin
        next_reg_rdata = depth_ctrl;
      end else if (reg_req.addr == REG_DEPTH_DISP) begin
        next_reg_rdata = depth_disp;
      end else if (reg_req.addr == REG_NORMAL_LVL) begin
        next_reg_rdata = normal_lvl;
      end else if (reg_req.addr == REG_MOD_LVL) begin
        next_reg_rdata = mod_lvl;
      end else if (reg_req.addr == REG_ADC_OUT) begin
        next_reg_rdata = adc_out;
      end else if (reg_req.addr == REG_STATUS) begin
        next_reg_rdata = {6'h00, done_flag, calibrating};
      end else begin
        next_reg_rdata = 8'h00;  // unmapped reads as zero
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_def    <= RST_AUX_DEF;
      protocol   <= RST_PROTOCOL;
      depth_ctrl <= RST_DEPTH_CTRL;
      normal_lvl <= RST_NORMAL_LVL;
      mod_lvl    <= RST_MOD_LVL;
      reg_rdata  <= 8'h00;
    end else begin
      aux_def    <= next_aux_def;
      protocol   <= next_protocol;
      depth_ctrl <= next_depth_ctrl;
      normal_lvl <= next_normal_lvl;
      mod_lvl    <= next_mod_lvl;
      reg_rdata  <= next_reg_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_settle_cnt = settle_cnt;
    next_target     = target;
    next_sar_code   = sar_code;
    next_probe      = probe;
    next_bit_idx    = bit_idx;
    next_best_code  = best_code;
    next_best_err   = best_err;
    next_adc_out    = adc_out;
    next_depth_disp = depth_disp;
    next_done_flag  = done_flag;
    next_cal_done   = 1'b0;
    case (state)
      ST_IDLE: begin
        if (cal_cmd) begin
          next_state      = ST_TX_ON;
          next_settle_cnt = 9'(SETTLE_CYC - 1);
          next_done_flag  = 1'b0;
          next_sar_code   = 8'h00;
          next_probe      = 8'h00;
        end
      end
      ST_TX_ON: begin
        // carrier at the unmodulated level must settle before measuring
        if (settle_cnt == 9'h000) begin
          next_state = ST_MEAS_REF;
        end else begin
          next_settle_cnt = settle_cnt - 9'h001;
        end
      end
      ST_MEAS_REF: begin
        next_state = ST_WAIT_REF;
      end
      ST_WAIT_REF: begin
        if (adc_done) begin
          next_adc_out = adc_value;
          next_state   = ST_CALC;
        end
      end
      ST_CALC: begin
        // target is fixed before the first driver trial
        next_target    = calc_target(adc_out, depth_ctrl[DEPTH_FRAC_MSB:DEPTH_FRAC_LSB]);
        next_best_code = 8'h00;
        next_best_err  = abs_diff(adc_out, next_target);
        next_bit_idx   = 3'h7;
        next_probe     = 8'h80;
        next_state     = ST_TRIAL;
      end
      ST_TRIAL: begin
        next_state = ST_WAIT_TRIAL;
      end
      ST_WAIT_TRIAL: begin
        if (adc_done) begin
          // still at or above target: keep the segment off, else restore it
          if (adc_value >= target) begin
            next_sar_code = probe;
          end
          if (err < best_err) begin
            next_best_err  = err;
            next_best_code = probe;
          end
          if (bit_idx == 3'h0) begin
            next_state = ST_FINISH;
          end else begin
            next_bit_idx = bit_idx - 3'h1;
            next_probe   = ((adc_value >= target) ? probe : sar_code) |
                           (8'h01 << (bit_idx - 3'h1));
            next_state   = ST_TRIAL;
          end
        end
      end
      ST_FINISH: begin
        next_depth_disp = best_code;
        next_done_flag  = 1'b1;
        next_cal_done   = 1'b1;
        next_state      = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      settle_cnt <= 9'h000;
      target     <= 8'h00;
      sar_code   <= 8'h00;
      probe      <= 8'h00;
      bit_idx    <= 3'h0;
      best_code  <= 8'h00;
      best_err   <= 8'hFF;
      adc_out    <= 8'h00;
      depth_disp <= 8'h00;
      done_flag  <= 1'b0;
      cal_done   <= 1'b0;
    end else begin
      state      <= next_state;
      settle_cnt <= next_settle_cnt;
      target     <= next_target;
      sar_code   <= next_sar_code;
      probe      <= next_probe;
      bit_idx    <= next_bit_idx;
      best_code  <= next_best_code;
      best_err   <= next_best_err;
      adc_out    <= next_adc_out;
      depth_disp <= next_depth_disp;
      done_flag  <= next_done_flag;
      cal_done   <= next_cal_done;
    end
  end

  // ----------------------------------------------------------------------
  // driver segments: a set code bit switches that weighted segment off
  // ----------------------------------------------------------------------
  always_comb begin
    seg_off = 8'hFF;
    if (next_state == ST_TRIAL || next_state == ST_WAIT_TRIAL) begin
      seg_off = next_probe;
    end else if (next_state != ST_IDLE) begin
      seg_off = next_normal_lvl;
    end else if (next_aux_def[AUX_TX_EN_BIT] && mod_active) begin
      if (!next_aux_def[AUX_AM_BIT]) begin
        seg_off = 8'hFF;
      end else if (next_depth_ctrl[DEPTH_SRC_BIT]) begin
        seg_off = next_mod_lvl;
      end else begin
        seg_off = next_depth_disp;
      end
    end else if (next_aux_def[AUX_TX_EN_BIT]) begin
      seg_off = next_normal_lvl;
    end
    next_drive.antenna_driver_out_a = ~seg_off;
    next_drive.antenna_driver_out_b = ~seg_off;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_cal_tx_on;
    @(posedge sys_clk) disable iff (!arst_n)
      cal_cmd |=> tx_on && (state == ST_TX_ON) ##1 tx_on;
  endproperty
  a_cal_tx_on: assert property (p_cal_tx_on) else $error("calibration did not start carrier");

  property p_ref_store;
    @(posedge sys_clk) disable iff (!arst_n)
      (state == ST_WAIT_REF && adc_done) |=> (adc_out == $past(adc_value)) && (state == ST_CALC);
  endproperty
  a_ref_store: assert property (p_ref_store) else $error("carrier measurement not stored");

  property p_target_calc;
    @(posedge sys_clk) disable iff (!arst_n)
      (state == ST_CALC) |=> (state == ST_TRIAL) &&
        ({6'h00, target} * (14'(FRAC_ONE) + {8'h00, depth_ctrl[DEPTH_FRAC_MSB:DEPTH_FRAC_LSB]})
         <= {adc_out, 6'h00});
  endproperty
  a_target_calc: assert property (p_target_calc) else $error("target exceeds divided measurement");

  property p_target_ratio;
    @(posedge sys_clk) disable iff (!arst_n)
      (state == ST_TRIAL) |-> (target <= adc_out);
  endproperty
  a_target_ratio: assert property (p_target_ratio) else $error("target above carrier level");

  property p_sar_keep;
    @(posedge sys_clk) disable iff (!arst_n)
      (state == ST_WAIT_TRIAL && adc_done) |=>
        (sar_code == (($past(adc_value) >= $past(target)) ? $past(probe) : $past(sar_code)));
  endproperty
  a_sar_keep: assert property (p_sar_keep) else $error("approximation step wrong");

  property p_finish_disp;
    @(posedge sys_clk) disable iff (!arst_n)
      (state == ST_FINISH) |=> (depth_disp == $past(best_code)) && cal_done && done_flag;
  endproperty
  a_finish_disp: assert property (p_finish_disp) else $error("display not loaded at finish");

  property p_done_pulse;
    @(posedge sys_clk) disable iff (!arst_n)
      cal_done |=> !cal_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done is not a single pulse");

  property p_ook;
    @(posedge sys_clk) disable iff (!arst_n)
      (!calibrating && aux_def[AUX_TX_EN_BIT] && !aux_def[AUX_AM_BIT] && mod_active &&
       !cal_cmd && !preset_cmd && !reg_req.wr) |=> (drive == '0);
  endproperty
  a_ook: assert property (p_ook) else $error("keying did not switch drivers off");

  property p_am_direct;
    @(posedge sys_clk) disable iff (!arst_n)
      (!calibrating && aux_def[AUX_TX_EN_BIT] && aux_def[AUX_AM_BIT] &&
       depth_ctrl[DEPTH_SRC_BIT] && mod_active && !cal_cmd && !preset_cmd && !reg_req.wr) |=>
        (drive.antenna_driver_out_a == ~$past(mod_lvl));
  endproperty
  a_am_direct: assert property (p_am_direct) else $error("direct modulated level not used");

  property p_unmod;
    @(posedge sys_clk) disable iff (!arst_n)
      (!calibrating && aux_def[AUX_TX_EN_BIT] && !mod_active && !cal_cmd && !reg_req.wr) |=>
        (drive.antenna_driver_out_a == ~$past(normal_lvl)) &&
        (drive.antenna_driver_out_b == drive.antenna_driver_out_a);
  endproperty
  a_unmod: assert property (p_unmod) else $error("unmodulated level wrong");

  property p_preset;
    @(posedge sys_clk) disable iff (!arst_n)
      (preset_cmd && !reg_req.wr) |=> (aux_def[AUX_AM_BIT] == $past(am_proto));
  endproperty
  a_preset: assert property (p_preset) else $error("preset chose wrong keying");

endmodule // amdc_depth_cal

// File: amdc_adc_model.sv
// amdc_adc_model: behavioural a/d converter and antenna field seen by the
// depth control block. assumes drive bytes are segment enables, bit7 heaviest.

`timescale 1ns/100ps

module amdc_adc_model
  import amdc_pkg::*;
#(
  parameter int FULL = 200                // field amplitude with all segments on
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic         adc_start,
  input  wire logic         slow,
  input  wire amdc_drive_t  drive,
  output logic              adc_done,
  output logic [7:0]        adc_value,
  output int                conv_count
);
  // ----------------------------------------------------------------------
  // conversion engine
  // ----------------------------------------------------------------------
  logic       busy;
  logic [2:0] cnt;
  logic [7:0] last;
  logic [7:0] amp;

  // field grows with the weight of the enabled segments
  assign amp = 8'((FULL * (int'(drive.antenna_driver_out_a) + 1)) >> 8);

  // answer a start after 1 or 5 cycles; data line drifts outside the done cycle
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy       <= 1'b0;
      cnt        <= 3'h0;
      adc_done   <= 1'b0;
      adc_value  <= 8'h00;
      last       <= 8'h00;
      conv_count <= 0;
    end else begin
      adc_done  <= 1'b0;
      adc_value <= ~last;
      if (busy) begin
        if (cnt == 3'h0) begin
          adc_done  <= 1'b1;
          adc_value <= amp;
          last      <= amp;
          busy      <= 1'b0;
        end else begin
          cnt <= cnt - 3'h1;
        end
      end else if (adc_start) begin
        busy       <= 1'b1;
        cnt        <= slow ? 3'h4 : 3'h0;
        conv_count <= conv_count + 1;
      end
    end
  end
endmodule // amdc_adc_model

// File: tb_top.sv
// tb_top: register and command tests for the modulation depth control block.
// assumes the behavioural converter model and a 40 MHz sys_clk.

`timescale 1ns/100ps

module tb_top
  import amdc_pkg::*;
;
  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  logic          sys_clk = 1'b0;
  logic          arst_n = 1'b0;
  amdc_reg_req_t req = '0;
  logic [7:0]    reg_rdata;
  logic          cmd_valid = 1'b0;
  logic [7:0]    cmd_code = 8'h00;
  logic          mod_active = 1'b0;
  logic          slow = 1'b0;
  logic          adc_start, adc_done, tx_on, cal_busy, cal_done;
  logic [7:0]    adc_value;
  amdc_drive_t   drive;
  int            conv_count, err_count = 0, checked = 0, n0;
  logic [7:0]    e;

  always #12.5 sys_clk = ~sys_clk;

  amdc_depth_cal #(.SETTLE_CYC(4)) amdc_depth_cal_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_req(req), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .mod_active(mod_active), .adc_start(adc_start), .adc_done(adc_done),
    .adc_value(adc_value), .tx_on(tx_on), .drive(drive), .cal_busy(cal_busy),
    .cal_done(cal_done));

  amdc_adc_model amdc_adc_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .adc_start(adc_start), .slow(slow), .drive(drive), .adc_done(adc_done),
    .adc_value(adc_value), .conv_count(conv_count));

  // ----------------------------------------------------------------------
  // host tasks and reference model
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x) begin
      $display("BAD %s expected %h seen %h", n, x, g);
      err_count++;
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2 req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge sys_clk);
    #2 req.wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] x, input string n);
    @(posedge sys_clk);
    #2 req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge sys_clk);
    #2 req.rd = 1'b0;
    chk(n, x, reg_rdata);
  endtask

  task automatic cmd(input logic [7:0] c);
    @(posedge sys_clk);
    #2 cmd_valid = 1'b1;
    cmd_code = c;
    @(posedge sys_clk);
    #2 cmd_valid = 1'b0;
  endtask

  // field amplitude for a segment enable byte
  function automatic int amp(input logic [7:0] d);
    return (200 * (int'(d) + 1)) >> 8;
  endfunction

  // expected trim code: closest trial of a successive approximation search
  function automatic logic [7:0] exp_cal(input logic [5:0] f);
    int t, m, bd, d;
    logic [7:0] code, best, p;
    t = (200 * 64) / (64 + int'(f));
    code = 8'h00;
    best = 8'h00;
    bd = (200 > t) ? 200 - t : t - 200;
    for (int b = 7; b >= 0; b--) begin
      p = code | (8'h01 << b);
      m = amp(~p);
      d = (m > t) ? m - t : t - m;
      if (d < bd) begin
        best = p;
        bd = d;
      end
      if (m >= t) code = p;
    end
    return best;
  endfunction

  task automatic cal(input logic [5:0] f, input logic s);
    slow = s;
    wr(REG_NORMAL_LVL, 8'h00);
    wr(REG_AUX_DEF, 8'h00);
    wr(REG_PROTOCOL, 8'h01);
    wr(REG_DEPTH_CTRL, {1'b0, f, 1'b0});
    n0 = conv_count;
    cmd(CMD_CAL_DEPTH);
    chk("busy", 8'h01, {7'h00, cal_busy});
    chk("tx_on", 8'h01, {7'h00, tx_on});
    cmd(CMD_ANALOG_PRESET);
    for (int i = 0; i < 2000 && cal_done !== 1'b1; i++) @(posedge sys_clk) #1;
    chk("cal_done", 8'h01, {7'h00, cal_done});
    chk("conversions", 8'd9, 8'(conv_count - n0));
    rd(REG_ADC_OUT, 8'd200, "adc_out");
    e = exp_cal(f);
    rd(REG_DEPTH_DISP, e, "depth_disp");
    rd(REG_STATUS, 8'h02, "status");
    rd(REG_AUX_DEF, 8'h00, "aux_busy_preset");
    wr(REG_AUX_DEF, 8'h28);
    mod_active = 1'b1;
    @(posedge sys_clk);
    #2 chk("drive_am", ~e, drive.antenna_driver_out_a);
    mod_active = 1'b0;
    rd(REG_NORMAL_LVL, 8'h00, "normal_kept");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    #(25 * 20000);
    err_count++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    #2 arst_n = 1'b1;
    chk("tx_rst", 8'h00, {7'h00, tx_on});
    chk("drive_rst", 8'h00, drive.antenna_driver_out_a);
    for (int a = 1; a <= 8; a++) rd(6'(a), 8'h00, "reset_value");
    wr(6'h3F, 8'h55);
    rd(6'h3F, 8'h00, "unmapped");
    wr(REG_DEPTH_DISP, 8'h55);
    rd(REG_DEPTH_DISP, 8'h00, "read_only");
    cmd(8'h55);
    rd(REG_STATUS, 8'h00, "unknown_cmd");
    // unmodulated level, on-off keying and direct modulated level
    wr(REG_AUX_DEF, 8'h08);
    wr(REG_NORMAL_LVL, 8'h0F);
    @(posedge sys_clk);
    #2 chk("drive_norm_a", 8'hF0, drive.antenna_driver_out_a);
    chk("drive_norm_b", 8'hF0, drive.antenna_driver_out_b);
    mod_active = 1'b1;
    @(posedge sys_clk);
    #2 chk("drive_ook", 8'h00, drive.antenna_driver_out_a);
    wr(REG_MOD_LVL, 8'h33);
    wr(REG_DEPTH_CTRL, 8'h80);
    wr(REG_AUX_DEF, 8'h28);
    @(posedge sys_clk);
    #2 chk("drive_direct", 8'hCC, drive.antenna_driver_out_a);
    mod_active = 1'b0;
    rd(REG_DEPTH_CTRL, 8'h80, "depth_ctrl");
    // preset over every protocol code
    for (int p = 0; p < 7; p++) begin
      wr(REG_AUX_DEF, 8'h00);
      wr(REG_PROTOCOL, 8'(p));
      cmd(CMD_ANALOG_PRESET);
      rd(REG_AUX_DEF, (p == 1 || p == 2 || p == 4 || p == 5) ? 8'h20 : 8'h00, "preset");
    end
    cal(6'h00, 1'b0);
    cal(6'h0E, 1'b1);
    cal(6'h20, 1'b0);
    cal(6'h3F, 1'b1);
    end_sim();
  end
endmodule // tb_top
